// ==== logic/chunk_pkg.sv ====
package chunk_pkg;

   // ************************************************************
   // Register map and field layout
   // ************************************************************
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned CNT_W    = 32;
   localparam logic [7:0]  OFS_MODE = 8'h00;
   localparam logic [7:0]  OFS_SEL  = 8'h04;
   localparam logic [7:0]  OFS_EN   = 8'h08;
   localparam logic [7:0]  OFS_UNIT = 8'h0c;
   localparam logic [7:0]  OFS_EVT  = 8'h10;
   localparam logic [7:0]  OFS_RST  = 8'h14;
   localparam logic [7:0]  OFS_CMD  = 8'h18;
   localparam logic [7:0]  OFS_FRM  = 8'h1c;
   localparam logic [7:0]  OFS_TRG  = 8'h20;
   localparam logic [7:0]  OFS_ENV  = 8'h24;
   localparam int unsigned MODE_BIT = 0;
   localparam int unsigned KIND_BIT = 1;
   localparam int unsigned EN_BIT   = 0;
   localparam int unsigned CMD_BIT  = 0;
   localparam int unsigned N_CHUNK  = 6;

   // ************************************************************
   // Reset values and chunk slots
   // ************************************************************
   localparam logic [N_CHUNK-1:0] EN_RESET  = 6'h00;
   localparam logic [CNT_W-1:0]   CNT_ZERO  = 32'h0000_0000;
   localparam logic [CNT_W-1:0]   CNT_STEP  = 32'h0000_0001;
   localparam logic [2:0]         SLOT_EXT3 = 3'h3;
   localparam logic [2:0]         SLOT_FRM  = 3'h4;
   localparam logic [2:0]         SLOT_TRG  = 3'h5;
   localparam logic [2:0]         SLOT_NONE = 3'h7;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      CH_EXT  = 3'h0,
      CH_FRM  = 3'h1,
      CH_TRG  = 3'h2,
      CH_TS   = 3'h3,
      CH_LINE = 3'h4,
      CH_CRC  = 3'h5
   } chunk_sel_t;

   typedef enum logic [1:0] {
      RS_OFF  = 2'h0,
      RS_PIN1 = 2'h1,
      RS_PIN2 = 2'h2,
      RS_SOFT = 2'h3
   } reset_src_t;

   typedef enum logic [1:0] {
      EV_NONE  = 2'h0,
      EV_BEGIN = 2'h1,
      EV_TRIG  = 2'h2
   } event_src_t;

   typedef enum logic {
      KIND_IMAGE = 1'b0,
      KIND_CHUNK = 1'b1
   } content_kind_t;

   typedef struct packed {
      logic [15:0] x_offset;
      logic [15:0] y_offset;
      logic [15:0] width;
      logic [15:0] height;
      logic [31:0] pixel_format;
      logic [15:0] range_min;
      logic [15:0] range_max;
   } image_info_t;

endpackage : chunk_pkg

// ==== logic/event_count_unit.sv ====
`timescale 1ns/100ps
module event_count_unit
#(
   parameter int unsigned W = 32
)
(
   input  wire logic         clock_i,
   input  wire logic         reset_n_i,
   input  wire logic         count_i,
   input  wire logic         clear_i,
   output logic [W-1:0]      value_o
);

   // ************************************************************
   // Counter
   // ************************************************************
   // A clear in the same cycle as an event counts that event from zero.
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         value_o <= '0;
      else if (clear_i && count_i)
         value_o <= W'(1);
      else if (clear_i)
         value_o <= '0;
      else if (count_i)
         value_o <= value_o + W'(1);
   end

endmodule : event_count_unit

// ==== logic/image_chunk_appender.sv ====
`timescale 1ns/100ps
module image_chunk_appender
(
   input  wire logic                          clock_i,
   input  wire logic                          reset_n_i,
   input  wire logic [chunk_pkg::ADDR_W-1:0]  paddr_i,
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [chunk_pkg::DATA_W-1:0]  pwdata_i,
   output logic [chunk_pkg::DATA_W-1:0]       prdata_o,
   output logic                               pready_o,
   output logic                               pslverr_o,
   input  wire logic                          frame_begin_event_i,
   input  wire chunk_pkg::image_info_t        image_info_i,
   input  wire logic                          image_done_i,
   input  wire logic                          frame_trigger_event_i,
   input  wire logic                          input_pin_one_i,
   input  wire logic                          input_pin_two_i,
   output chunk_pkg::content_kind_t           transfer_content_kind_o,
   output logic                               chunk_valid_o,
   input  wire logic                          chunk_ready_i,
   output logic [chunk_pkg::DATA_W-1:0]       chunk_data_o,
   output logic                               chunk_last_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } send_state_t;

   logic                           mode_r;
   logic [2:0]                     sel_r;
   logic [chunk_pkg::N_CHUNK-1:0]  en_r;
   logic                           unit_r;
   chunk_pkg::event_src_t          evt_frm_r;
   chunk_pkg::event_src_t          evt_trg_r;
   chunk_pkg::reset_src_t          rs_frm_r;
   chunk_pkg::reset_src_t          rs_trg_r;
   logic [2:0]                     sync1_r;
   logic [2:0]                     sync2_r;
   logic [2:0]                     sync3_r;
   logic [2:0]                     rise;
   logic                           wr;
   logic                           rd_setup;
   logic                           sw_clear;
   logic                           clr_frm;
   logic                           clr_trg;
   logic [chunk_pkg::CNT_W-1:0]    frm_value;
   logic [chunk_pkg::CNT_W-1:0]    trg_value;
   logic [chunk_pkg::CNT_W-1:0]    frm_snap_r;
   logic [chunk_pkg::CNT_W-1:0]    trg_snap_r;
   chunk_pkg::image_info_t         info_r;
   logic [2:0]                     plan_r;
   logic [2:0]                     plan_now;
   logic [2:0]                     slot_r;
   logic [2:0]                     first;
   logic [2:0]                     after;
   send_state_t                    state_r;
   logic                           err_r;
   logic                           start;
   logic                           advance;

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic slot_en(input logic [2:0] plan,
                                    input logic [2:0] j);
      logic r;
      r = 1'b0;
      if (j <= chunk_pkg::SLOT_EXT3)
         r = plan[0];
      else if (j == chunk_pkg::SLOT_FRM)
         r = plan[1];
      else if (j == chunk_pkg::SLOT_TRG)
         r = plan[2];
      return r;
   endfunction : slot_en

   // Smallest enabled slot at or above lo, or none.
   function automatic logic [2:0] first_slot(input logic [2:0] plan,
                                             input logic [2:0] lo);
      logic [2:0] r;
      r = chunk_pkg::SLOT_NONE;
      for (int j = 5; j >= 0; j--)
      begin
         if (3'(j) >= lo && slot_en(plan, 3'(j)))
            r = 3'(j);
      end
      return r;
   endfunction : first_slot

   function automatic logic [chunk_pkg::DATA_W-1:0] word_of(
      input logic [2:0] j, input chunk_pkg::image_info_t inf,
      input logic [31:0] frm, input logic [31:0] trg);
      logic [chunk_pkg::DATA_W-1:0] r;
      r = '0;
      unique case (j)
         3'h0: r = {inf.x_offset, inf.y_offset};
         3'h1: r = {inf.width, inf.height};
         3'h2: r = inf.pixel_format;
         3'h3: r = {inf.range_min, inf.range_max};
         3'h4: r = frm;
         3'h5: r = trg;
         default: r = '0;
      endcase
      return r;
   endfunction : word_of

   function automatic logic mapped(input logic [7:0] a);
      return a == chunk_pkg::OFS_MODE || a == chunk_pkg::OFS_SEL ||
             a == chunk_pkg::OFS_EN   || a == chunk_pkg::OFS_UNIT ||
             a == chunk_pkg::OFS_EVT  || a == chunk_pkg::OFS_RST ||
             a == chunk_pkg::OFS_CMD  || a == chunk_pkg::OFS_FRM ||
             a == chunk_pkg::OFS_TRG  || a == chunk_pkg::OFS_ENV;
   endfunction : mapped

   function automatic logic plan_en(input logic [2:0] s);
      logic [chunk_pkg::N_CHUNK-1:0] v;
      v = {en_r[5:1], mode_r};
      return v[s];
   endfunction : plan_en

   // ************************************************************
   // Register bus
   // ************************************************************
   assign wr       = psel_i && penable_i && pwrite_i && mapped(paddr_i);
   assign rd_setup = psel_i && !penable_i;
   assign pready_o = 1'b1;
   assign pslverr_o = err_r && psel_i && penable_i;

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prdata_o <= '0;
         err_r    <= 1'b0;
      end
      else if (rd_setup)
      begin
         err_r    <= !mapped(paddr_i);
         prdata_o <= '0;
         unique case (paddr_i)
            chunk_pkg::OFS_MODE:
            begin
               prdata_o[chunk_pkg::MODE_BIT] <= mode_r;
               prdata_o[chunk_pkg::KIND_BIT] <= transfer_content_kind_o;
            end
            chunk_pkg::OFS_SEL:  prdata_o[2:0] <= sel_r;
            chunk_pkg::OFS_EN:
            begin
               if (sel_r < 3'(chunk_pkg::N_CHUNK))
                  prdata_o[chunk_pkg::EN_BIT] <= plan_en(sel_r);
            end
            chunk_pkg::OFS_UNIT: prdata_o[0] <= unit_r;
            chunk_pkg::OFS_EVT:  prdata_o[1:0] <= unit_r ? evt_frm_r : evt_trg_r;
            chunk_pkg::OFS_RST:  prdata_o[1:0] <= unit_r ? rs_frm_r : rs_trg_r;
            chunk_pkg::OFS_FRM:  prdata_o <= frm_value;
            chunk_pkg::OFS_TRG:  prdata_o <= trg_value;
            chunk_pkg::OFS_ENV:
               prdata_o[chunk_pkg::N_CHUNK-1:0] <= {en_r[5:1], mode_r};
            default: prdata_o <= '0;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         mode_r <= 1'b0;
      else if (wr && paddr_i == chunk_pkg::OFS_MODE)
         mode_r <= pwdata_i[chunk_pkg::MODE_BIT];
   end

   assign transfer_content_kind_o = mode_r ? chunk_pkg::KIND_CHUNK
                                           : chunk_pkg::KIND_IMAGE;

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         sel_r <= 3'h0;
      else if (wr && paddr_i == chunk_pkg::OFS_SEL)
         sel_r <= pwdata_i[2:0];
   end

   // Bit 0 is never stored: the extended chunk follows the mode itself.
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         en_r <= chunk_pkg::EN_RESET;
      else if (!mode_r || (wr && paddr_i == chunk_pkg::OFS_MODE &&
                           !pwdata_i[chunk_pkg::MODE_BIT]))
         en_r <= chunk_pkg::EN_RESET;
      else if (wr && paddr_i == chunk_pkg::OFS_EN && sel_r != 3'h0 &&
               sel_r < 3'(chunk_pkg::N_CHUNK))
         en_r[sel_r] <= pwdata_i[chunk_pkg::EN_BIT];
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         unit_r    <= 1'b0;
         evt_frm_r <= chunk_pkg::EV_BEGIN;
         evt_trg_r <= chunk_pkg::EV_TRIG;
         rs_frm_r  <= chunk_pkg::RS_OFF;
         rs_trg_r  <= chunk_pkg::RS_OFF;
      end
      else if (wr)
      begin
         if (paddr_i == chunk_pkg::OFS_UNIT)
            unit_r <= pwdata_i[0];
         if (paddr_i == chunk_pkg::OFS_EVT && unit_r)
            evt_frm_r <= chunk_pkg::event_src_t'(pwdata_i[1:0]);
         if (paddr_i == chunk_pkg::OFS_EVT && !unit_r)
            evt_trg_r <= chunk_pkg::event_src_t'(pwdata_i[1:0]);
         if (paddr_i == chunk_pkg::OFS_RST && unit_r)
            rs_frm_r <= chunk_pkg::reset_src_t'(pwdata_i[1:0]);
         if (paddr_i == chunk_pkg::OFS_RST && !unit_r)
            rs_trg_r <= chunk_pkg::reset_src_t'(pwdata_i[1:0]);
      end
   end

   // ************************************************************
   // Pin synchronisers and counter clears
   // ************************************************************
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         sync3_r <= 3'h0;
      end
      else
      begin
         sync1_r <= {frame_trigger_event_i, input_pin_two_i,
                     input_pin_one_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign rise     = sync2_r & ~sync3_r;
   assign sw_clear = wr && paddr_i == chunk_pkg::OFS_CMD &&
                     pwdata_i[chunk_pkg::CMD_BIT];

   // A source of off never clears, so a reset stays impossible until set.
   assign clr_frm = (rs_frm_r == chunk_pkg::RS_PIN1 && rise[0]) ||
                    (rs_frm_r == chunk_pkg::RS_PIN2 && rise[1]) ||
                    (rs_frm_r == chunk_pkg::RS_SOFT && sw_clear &&
                     unit_r);
   assign clr_trg = (rs_trg_r == chunk_pkg::RS_PIN1 && rise[0]) ||
                    (rs_trg_r == chunk_pkg::RS_PIN2 && rise[1]) ||
                    (rs_trg_r == chunk_pkg::RS_SOFT && sw_clear &&
                     !unit_r);

   // ************************************************************
   // Counters
   // ************************************************************
   // Natural overflow of the full width gives the wrap to zero.
   event_count_unit #(.W(chunk_pkg::CNT_W)) frame_count_unit
   (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .count_i   (frame_begin_event_i),
      .clear_i   (clr_frm),
      .value_o   (frm_value)
   );

   // Starting from zero, the first trigger shows one.
   event_count_unit #(.W(chunk_pkg::CNT_W)) trigger_count_unit
   (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .count_i   (rise[2]),
      .clear_i   (clr_trg),
      .value_o   (trg_value)
   );

   // The stamp sees a clear from the same cycle, so it is never late.
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         frm_snap_r <= chunk_pkg::CNT_ZERO;
         trg_snap_r <= chunk_pkg::CNT_ZERO;
         info_r     <= '0;
      end
      else if (frame_begin_event_i)
      begin
         frm_snap_r <= clr_frm ? chunk_pkg::CNT_ZERO : frm_value;
         trg_snap_r <= clr_trg ? chunk_pkg::CNT_ZERO : trg_value;
         info_r     <= image_info_i;
      end
   end

   // ************************************************************
   // Trailing chunk stream
   // ************************************************************
   // An image that ends while a trailer is still going out gets none;
   // its count value is then skipped, as buffering may do anyway.
   assign plan_now = {en_r[chunk_pkg::CH_TRG], en_r[chunk_pkg::CH_FRM],
                      mode_r};
   assign first    = first_slot(plan_now, 3'h0);
   assign start    = state_r == ST_IDLE && image_done_i &&
                     first != chunk_pkg::SLOT_NONE;
   assign advance  = state_r == ST_SEND && chunk_ready_i;
   assign after    = first_slot(plan_r, slot_r + 3'h1);

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r       <= ST_IDLE;
         plan_r        <= 3'h0;
         slot_r        <= chunk_pkg::SLOT_NONE;
         chunk_data_o  <= '0;
         chunk_last_o  <= 1'b0;
      end
      else if (start)
      begin
         state_r      <= ST_SEND;
         plan_r       <= plan_now;
         slot_r       <= first;
         chunk_data_o <= word_of(first, info_r, frm_snap_r, trg_snap_r);
         chunk_last_o <= first_slot(plan_now, first + 3'h1) ==
                         chunk_pkg::SLOT_NONE;
      end
      else if (advance && chunk_last_o)
      begin
         state_r      <= ST_IDLE;
         slot_r       <= chunk_pkg::SLOT_NONE;
         chunk_last_o <= 1'b0;
      end
      else if (advance)
      begin
         slot_r       <= after;
         chunk_data_o <= word_of(after, info_r, frm_snap_r, trg_snap_r);
         chunk_last_o <= first_slot(plan_r, after + 3'h1) ==
                         chunk_pkg::SLOT_NONE;
      end
   end

   assign chunk_valid_o = state_r == ST_SEND;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   a_kind_follows_mode: assert property (
      wr && paddr_i == chunk_pkg::OFS_MODE |=>
      transfer_content_kind_o == $past(pwdata_i[chunk_pkg::MODE_BIT]))
      else $error("content kind does not follow chunk mode");
   a_off_clears_all: assert property (
      wr && paddr_i == chunk_pkg::OFS_MODE &&
      !pwdata_i[chunk_pkg::MODE_BIT] |=> en_r == chunk_pkg::EN_RESET)
      else $error("chunk enables survive mode off");
   a_enable_needs_mode: assert property (
      (en_r & ~$past(en_r)) != '0 |-> $past(mode_r))
      else $error("chunk enabled without chunk mode");
   a_ext_leads_trailer: assert property (
      start && mode_r |=> chunk_valid_o && slot_r == 3'h0)
      else $error("trailer does not begin with extended data");
   a_frame_count_step: assert property (
      frame_begin_event_i && !clr_frm |=>
      frm_value == $past(frm_value) + chunk_pkg::CNT_STEP)
      else $error("frame count did not step by one");
   a_trig_count_step: assert property (
      rise[2] && !clr_trg |=>
      trg_value == $past(trg_value) + chunk_pkg::CNT_STEP)
      else $error("trigger count did not step by one");
   a_soft_clear: assert property (
      sw_clear && unit_r && rs_frm_r == chunk_pkg::RS_SOFT &&
      !frame_begin_event_i |=> frm_value == chunk_pkg::CNT_ZERO)
      else $error("software clear did not clear frame count");
   a_off_no_clear: assert property (
      clr_frm |-> rs_frm_r != chunk_pkg::RS_OFF)
      else $error("frame count cleared with source off");
   a_pin_clear: assert property (
      $rose(sync2_r[0]) && rs_frm_r == chunk_pkg::RS_PIN1 &&
      !frame_begin_event_i |=> frm_value == chunk_pkg::CNT_ZERO)
      else $error("pin edge did not clear frame count");
   a_stamp_frame: assert property (
      frame_begin_event_i && !clr_frm |=>
      frm_snap_r == $past(frm_value))
      else $error("frame stamp is not the current count");
   a_hold_word: assert property (
      chunk_valid_o && !chunk_ready_i |=>
      chunk_valid_o && $stable(chunk_data_o) && $stable(chunk_last_o))
      else $error("chunk word changed before it was taken");

   c_full_trailer: cover property (
      chunk_valid_o && slot_r == chunk_pkg::SLOT_TRG && chunk_ready_i);
   c_frame_wrap: cover property (
      frame_begin_event_i && frm_value == '1);
   c_pin_two_clear: cover property (clr_frm && rise[1]);

endmodule : image_chunk_appender

// ==== test/host_sink.sv ====
`timescale 1ns/100ps
module host_sink
(
   input  wire logic        clock_i,
   input  wire logic        valid_i,
   input  wire logic [31:0] data_i,
   input  wire logic        slow_i,
   input  wire logic        last_i,
   output logic             ready_o
);
   logic [31:0] word_q [$];
   logic        ready_r = 1'b0;
   int          last_at = 0;

   assign ready_o = ready_r;

   // A slow host stalls every other cycle, so held trailer words get tested.
   always @(posedge clock_i)
   begin
      if (valid_i && ready_r)
      begin
         word_q.push_back(data_i);
         if (last_i)
            last_at = word_q.size();
      end
      ready_r <= slow_i ? ~ready_r : 1'b1;
   end
endmodule : host_sink

// ==== test/image_chunk_appender_tb.sv ====
`timescale 1ns/100ps
module image_chunk_appender_tb;
   logic                     clock_i = 1'b0, reset_n_i = 1'b0;
   logic [7:0]               paddr_i = 8'h00;
   logic                     psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [31:0]              pwdata_i = 32'h0, prdata_o, q, chunk_data_o;
   logic                     pready_o, pslverr_o, err, chunk_valid_o;
   logic                     chunk_last_o, chunk_ready_i, slow = 1'b0;
   logic                     frame_begin_event_i = 1'b0, image_done_i = 1'b0;
   logic                     frame_trigger_event_i = 1'b0;
   logic                     input_pin_one_i = 1'b0, input_pin_two_i = 1'b0;
   chunk_pkg::content_kind_t transfer_content_kind_o;
   chunk_pkg::image_info_t   image_info_i = {16'h0010, 16'h0020, 16'h0280,
      16'h01e0, 32'h0108_0001, 16'h0004, 16'h00ff};
   logic [31:0]              e [6];
   int                       n_fail = 0, tests_run = 0;

   always #5 clock_i = ~clock_i;

   image_chunk_appender image_chunk_appender_inst
   (
      .clock_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .frame_begin_event_i,
      .image_info_i, .image_done_i, .frame_trigger_event_i,
      .input_pin_one_i, .input_pin_two_i, .transfer_content_kind_o,
      .chunk_valid_o, .chunk_ready_i, .chunk_data_o, .chunk_last_o
   );

   host_sink host_sink_inst
   (
      .clock_i, .valid_i(chunk_valid_o), .data_i(chunk_data_o),
      .slow_i(slow), .last_i(chunk_last_o), .ready_o(chunk_ready_i)
   );

   task automatic stop_test;
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      tests_run++;
      if (s !== x)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, s, x);
      end
   endtask : chk

   // The request stands until pready is seen high at a rising edge.
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1)
         @(posedge clock_i);
      q   = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (!w)
         chk(q, d);
   endtask : acc

   task automatic pins(input logic [2:0] m);
      @(posedge clock_i);
      {frame_trigger_event_i, input_pin_two_i, input_pin_one_i} <= m;
      repeat (3) @(posedge clock_i);
      {frame_trigger_event_i, input_pin_two_i, input_pin_one_i} <= 3'h0;
      repeat (6) @(posedge clock_i);
   endtask : pins

   task automatic frame;
      @(posedge clock_i);
      frame_begin_event_i <= 1'b1;
      @(posedge clock_i);
      frame_begin_event_i <= 1'b0;
   endtask : frame

   task automatic tail(input int n);
      @(posedge clock_i);
      image_done_i <= 1'b1;
      @(posedge clock_i);
      image_done_i <= 1'b0;
      for (int i = 0; i < 60 && host_sink_inst.word_q.size() < n; i++)
         @(posedge clock_i);
   endtask : tail

   initial
   begin
      #200us;
      n_fail++;
      stop_test();
   end

   initial
   begin
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      acc(1'b0, chunk_pkg::OFS_MODE, 32'h0);
      acc(1'b0, chunk_pkg::OFS_RST, 32'h0);
      acc(1'b1, chunk_pkg::OFS_SEL, 32'h1);
      acc(1'b1, chunk_pkg::OFS_EN, 32'h1);
      acc(1'b0, chunk_pkg::OFS_ENV, 32'h0);
      acc(1'b1, chunk_pkg::OFS_MODE, 32'h1);
      @(negedge clock_i);
      chk({31'h0, transfer_content_kind_o}, 32'h1);
      acc(1'b0, chunk_pkg::OFS_ENV, 32'h1);
      for (int s = 1; s < 3; s++)
      begin
         acc(1'b1, chunk_pkg::OFS_SEL, 32'(s));
         acc(1'b1, chunk_pkg::OFS_EN, 32'h1);
      end
      acc(1'b0, chunk_pkg::OFS_ENV, 32'h7);
      for (int f = 0; f < 2; f++)
      begin
         slow <= f[0];
         pins(3'h4);
         frame();
         tail(6 * (f + 1));
         e = '{{image_info_i.x_offset, image_info_i.y_offset},
               {image_info_i.width, image_info_i.height},
               image_info_i.pixel_format,
               {image_info_i.range_min, image_info_i.range_max},
               32'(f), 32'(f + 1)};
         for (int w = 0; w < 6; w++)
            chk(host_sink_inst.word_q[6 * f + w], e[w]);
         chk(host_sink_inst.last_at, 6 * (f + 1));
      end
      acc(1'b0, chunk_pkg::OFS_FRM, 32'h2);
      acc(1'b1, chunk_pkg::OFS_UNIT, 32'h1);
      acc(1'b1, chunk_pkg::OFS_EVT, 32'h1);
      acc(1'b1, chunk_pkg::OFS_RST, 32'h3);
      acc(1'b1, chunk_pkg::OFS_CMD, 32'h1);
      acc(1'b0, chunk_pkg::OFS_FRM, 32'h0);
      for (int p = 1; p < 3; p++)
      begin
         acc(1'b1, chunk_pkg::OFS_RST, 32'(p));
         frame();
         pins(3'(p));
         acc(1'b0, chunk_pkg::OFS_FRM, 32'h0);
      end
      acc(1'b1, chunk_pkg::OFS_RST, 32'h0);
      frame();
      pins(3'h3);
      acc(1'b0, chunk_pkg::OFS_FRM, 32'h1);
      acc(1'b0, chunk_pkg::OFS_TRG, 32'h2);
      acc(1'b1, chunk_pkg::OFS_MODE, 32'h0);
      acc(1'b0, chunk_pkg::OFS_ENV, 32'h0);
      tail(13);
      chk(host_sink_inst.word_q.size(), 32'd12);
      acc(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      stop_test();
   end
endmodule : image_chunk_appender_tb
